//--- hdl/monitor_result_registers.sv
// Operation
// - The bus voltage result always holds the code of the most recently completed conversion, clamped to full scale.
// - The 13-bit bus code sits in bits 15 to 3 with a 4 mV step.
// - Full scale is code 1F40 in the 32 V range and code 0FA0 in the 16 V range.
// - The ready flag in bit 1 sets only after the conversion and both the current and power products are done.
// - Result registers are readable at any time and show the last completed conversion.
// - Writing a new operating mode clears the ready flag unless the mode is power-down or disable.
// - Reading the power result clears the ready flag.
// - The overflow flag in bit 0 sets when the current or power product goes out of range.
// - The power result is read-only, resets to zero and is the current magnitude times bus voltage.
// - The current result is read-only, resets to zero and is two's complement with bit 15 as sign.
// - The current result is the shunt code times the calibration scale.
// - The calibration scale is writable, resets to zero and only bits 15 to 1 enter the products.
// - Bit 0 of the calibration scale always reads zero and ignores a written one.
// - Range and step of current and power follow from the calibration scale.
`timescale 1ns/1ns
`include "monitor_result_defines.svh"
module monitor_result_registers
   import monitor_result_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   input  wire logic        i_mode_wr,
   input  wire logic [2:0]  i_mode,
   input  wire logic        i_conv_done,
   input  wire logic [15:0] i_shunt_code,
   input  wire logic [12:0] i_bus_code,
   input  wire logic        i_range_32v,
   output logic             o_conversion_ready_flag,
   output logic             o_busy
);

   calc_state_t state_r;
   calc_state_t state_nxt;
   logic [15:0] shunt_r;
   logic [15:0] shunt_nxt;
   logic [12:0] bus_r;
   logic [12:0] bus_nxt;
   logic [12:0] bus_clamped;
   logic [12:0] full_scale;

   logic [15:0] cal_r;
   logic [15:0] cal_nxt;
   logic [12:0] bus_code_r;
   logic [12:0] bus_code_nxt;
   logic [15:0] current_r;
   logic [15:0] current_nxt;
   logic [15:0] power_r;
   logic [15:0] power_nxt;
   logic        ready_r;
   logic        ready_nxt;
   logic        ovf_r;
   logic        ovf_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;

   logic [15:0] cur_prod;
   logic        cur_ovf;
   logic [15:0] pwr_prod;
   logic        pwr_ovf;
   logic [15:0] cur_mag;
   logic [15:0] cal_used;
   logic [15:0] bus_word;
   logic        commit;
   logic        ready_clear;

   // The void bit is forced low so only the upper fifteen bits scale.
   assign cal_used = {cal_r[15:1], 1'b0};

   scaled_multiplier
   #(
      .SHIFT        (`CURRENT_SHIFT),
      .UNSIGNED_OUT (1'b0)
   )
   u_current_mult
   (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .i_a        ($signed(shunt_r)),
      .i_b        (cal_used),
      .o_product  (cur_prod),
      .o_overflow (cur_ovf)
   );

   // Power is a magnitude, so the current sign is dropped before the product.
   assign cur_mag = cur_prod[15] ? (16'h0000 - cur_prod) : cur_prod;

   scaled_multiplier
   #(
      .SHIFT        (`POWER_SHIFT),
      .UNSIGNED_OUT (1'b1)
   )
   u_power_mult
   (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .i_a        ($signed(cur_mag)),
      .i_b        ({3'h0, bus_r}),
      .o_product  (pwr_prod),
      .o_overflow (pwr_ovf)
   );

   assign full_scale  = i_range_32v ? `BUS_FULL_SCALE_32V : `BUS_FULL_SCALE_16V;
   assign bus_clamped = (i_bus_code > full_scale) ? full_scale : i_bus_code;

   always_comb
   begin
      state_nxt = state_r;
      shunt_nxt = shunt_r;
      bus_nxt   = bus_r;
      commit    = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            // A conversion that ends while the products run is dropped; the front end paces slower.
            if (i_conv_done)
            begin
               shunt_nxt = i_shunt_code;
               bus_nxt   = bus_clamped;
               state_nxt = ST_MUL_I;
            end
         end
         ST_MUL_I:
         begin
            state_nxt = ST_MUL_P;
         end
         ST_MUL_P:
         begin
            state_nxt = ST_COMMIT;
         end
         ST_COMMIT:
         begin
            commit    = 1'b1;
            state_nxt = ST_IDLE;
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r <= ST_IDLE;
         shunt_r <= 16'h0000;
         bus_r   <= 13'h0000;
      end
      else
      begin
         state_r <= state_nxt;
         shunt_r <= shunt_nxt;
         bus_r   <= bus_nxt;
      end
   end

   assign ready_clear = (i_reg_rd && (i_reg_addr == `ADDR_POWER_RESULT))
                        || (i_mode_wr && (i_mode != `MODE_POWER_DOWN)
                            && (i_mode != `MODE_DISABLE));

   always_comb
   begin
      cal_nxt      = cal_r;
      bus_code_nxt = bus_code_r;
      current_nxt  = current_r;
      power_nxt    = power_r;
      ovf_nxt      = ovf_r;
      ready_nxt    = ready_r;
      if (i_reg_wr && (i_reg_addr == `ADDR_CALIBRATION_SCALE))
      begin
         cal_nxt = {i_reg_wdata[15:1], 1'b0};
      end
      if (ready_clear)
      begin
         ready_nxt = 1'b0;
      end
      // All results and both flags move on the same edge, and a set outranks a clear.
      if (commit)
      begin
         bus_code_nxt = bus_r;
         current_nxt  = cur_prod;
         power_nxt    = pwr_prod;
         ovf_nxt      = cur_ovf | pwr_ovf;
         ready_nxt    = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cal_r      <= `RST_CALIBRATION_SCALE;
         bus_code_r <= 13'(`RST_BUS_VOLTAGE_RESULT >> `BUS_CODE_LSB_POS);
         current_r  <= `RST_CURRENT_RESULT;
         power_r    <= `RST_POWER_RESULT;
         ovf_r      <= 1'b0;
         ready_r    <= 1'b0;
      end
      else
      begin
         cal_r      <= cal_nxt;
         bus_code_r <= bus_code_nxt;
         current_r  <= current_nxt;
         power_r    <= power_nxt;
         ovf_r      <= ovf_nxt;
         ready_r    <= ready_nxt;
      end
   end

   always_comb
   begin
      bus_word = 16'h0000;
      bus_word[`BUS_CODE_MSB_POS:`BUS_CODE_LSB_POS] = bus_code_r;
      bus_word[`BUS_UNUSED_POS] = 1'b0;
      bus_word[`CONV_READY_POS] = ready_r;
      bus_word[`MATH_OVF_POS]   = ovf_r;
   end

   // Reads never wait on the ready flag; they return whatever was last committed.
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            `ADDR_BUS_VOLTAGE_RESULT: rdata_nxt = bus_word;
            `ADDR_POWER_RESULT:       rdata_nxt = power_r;
            `ADDR_CURRENT_RESULT:     rdata_nxt = current_r;
            `ADDR_CALIBRATION_SCALE:  rdata_nxt = cal_r;
            default:                  rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rdata_r <= 16'h0000;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_reg_rdata             = rdata_r;
   assign o_conversion_ready_flag = ready_r;
   assign o_busy                  = (state_r != ST_IDLE);

endmodule : monitor_result_registers

//--- include/monitor_result_defines.svh
`ifndef MONITOR_RESULT_DEFINES_SVH
`define MONITOR_RESULT_DEFINES_SVH

// Register pointer values.
`define ADDR_BUS_VOLTAGE_RESULT  8'h02
`define ADDR_POWER_RESULT        8'h03
`define ADDR_CURRENT_RESULT      8'h04
`define ADDR_CALIBRATION_SCALE   8'h05

// Reset values.
`define RST_BUS_VOLTAGE_RESULT   16'h0000
`define RST_POWER_RESULT         16'h0000
`define RST_CURRENT_RESULT       16'h0000
`define RST_CALIBRATION_SCALE    16'h0000

// Bus voltage and calibration scale register field layout.
`define BUS_CODE_MSB_POS         15
`define BUS_CODE_LSB_POS         3
`define BUS_UNUSED_POS           2
`define CONV_READY_POS           1
`define MATH_OVF_POS             0
`define SCALE_VOID_POS           0

// Bus voltage code step and full-scale codes.
`define BUS_STEP_MV              4
`define BUS_FULL_SCALE_32V       13'h1F40
`define BUS_FULL_SCALE_16V       13'h0FA0

// Operating mode codes that leave the ready flag untouched when written.
`define MODE_POWER_DOWN          3'h0
`define MODE_DISABLE             3'h4

// Right shifts applied after each product.
`define CURRENT_SHIFT            12
`define POWER_SHIFT              12

`endif

//--- include/monitor_result_pkg.sv
package monitor_result_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'h0,
      ST_MUL_I  = 2'h1,
      ST_MUL_P  = 2'h3,
      ST_COMMIT = 2'h2
   } calc_state_t;

endpackage : monitor_result_pkg

//--- hdl/scaled_multiplier.sv
`timescale 1ns/1ns
module scaled_multiplier
#(
   parameter int SHIFT        = 12,
   parameter bit UNSIGNED_OUT = 1'b0
)
(
   input  wire logic               i_clk,
   input  wire logic               i_rstn,
   input  wire logic signed [15:0] i_a,
   input  wire logic        [15:0] i_b,
   output logic             [15:0] o_product,
   output logic                    o_overflow
);

   logic signed [32:0] prod;
   logic signed [32:0] scaled;
   logic        [15:0] product_nxt;
   logic               overflow_nxt;
   logic        [15:0] product_r;
   logic               overflow_r;

   always_comb
   begin
      prod         = i_a * $signed({1'b0, i_b});
      scaled       = prod >>> SHIFT;
      product_nxt  = scaled[15:0];
      overflow_nxt = 1'b0;
      // Out-of-range results saturate so a flagged value is at least the right sign.
      if (UNSIGNED_OUT)
      begin
         if (scaled < 0)
         begin
            product_nxt  = 16'h0000;
            overflow_nxt = 1'b1;
         end
         else if (scaled > 33'sd65535)
         begin
            product_nxt  = 16'hFFFF;
            overflow_nxt = 1'b1;
         end
      end
      else
      begin
         if (scaled > 33'sd32767)
         begin
            product_nxt  = 16'h7FFF;
            overflow_nxt = 1'b1;
         end
         else if (scaled < -33'sd32768)
         begin
            product_nxt  = 16'h8000;
            overflow_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         product_r  <= 16'h0000;
         overflow_r <= 1'b0;
      end
      else
      begin
         product_r  <= product_nxt;
         overflow_r <= overflow_nxt;
      end
   end

   assign o_product  = product_r;
   assign o_overflow = overflow_r;

endmodule : scaled_multiplier

//--- verification/monitor_result_props.sv
`timescale 1ns/1ns
module monitor_result_props
(
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic [7:0]  i_reg_addr,
   input wire logic        i_reg_rd,
   input wire logic        i_mode_wr,
   input wire logic [2:0]  i_mode,
   input wire logic        i_conv_done,
   input wire logic [15:0] o_reg_rdata,
   input wire logic        o_conversion_ready_flag,
   input wire logic        o_busy
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   chk_busy_span: assert property (i_conv_done && !o_busy |=> o_busy[*3] ##1 !o_busy)
      else $error("busy span wrong");
   chk_ready_commit: assert property ($fell(o_busy) |-> o_conversion_ready_flag)
      else $error("ready missing at commit");
   chk_ready_source: assert property ($rose(o_conversion_ready_flag) |-> $past(o_busy))
      else $error("ready rose without commit");
   chk_power_read_clear: assert property (i_reg_rd && i_reg_addr == 8'h03 && !o_busy
      |=> !o_conversion_ready_flag)
      else $error("power read kept ready");
   chk_mode_clear: assert property (i_mode_wr && !o_busy && i_mode != 3'h0 && i_mode != 3'h4
      |=> !o_conversion_ready_flag)
      else $error("mode write kept ready");
   chk_mode_keep: assert property (o_conversion_ready_flag && i_mode_wr && !i_reg_rd
      && (i_mode == 3'h0 || i_mode == 3'h4) |=> o_conversion_ready_flag)
      else $error("idle mode cleared ready");
   chk_bus_bit_two: assert property (i_reg_rd && i_reg_addr == 8'h02 |=> !o_reg_rdata[2])
      else $error("bus bit 2 set");
   chk_scale_void_bit: assert property (i_reg_rd && i_reg_addr == 8'h05 |=> !o_reg_rdata[0])
      else $error("scale bit 0 set");
   chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data moved");
endmodule : monitor_result_props

bind monitor_result_registers monitor_result_props chk
(
   .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
   .i_mode_wr(i_mode_wr), .i_mode(i_mode), .i_conv_done(i_conv_done), .o_reg_rdata(o_reg_rdata),
   .o_conversion_ready_flag(o_conversion_ready_flag), .o_busy(o_busy)
);

//--- verification/monitor_host_model.sv
`timescale 1ns/1ns
module monitor_host_model
(
   input  wire logic        i_clk,
   input  wire logic [15:0] i_reg_rdata,
   output logic      [7:0]  o_reg_addr,
   output logic             o_reg_wr,
   output logic      [15:0] o_reg_wdata,
   output logic             o_reg_rd
);
   initial
   begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 16'h0000;
      o_reg_rd = 1'b0;
   end
   // Released lines show the inverse so a stale value is never mistaken for a held one.
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge i_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      d = i_reg_rdata;
   endtask : rd
   function automatic logic [12:0] bus_code_of(input logic [15:0] r);
      return r[15:3];
   endfunction : bus_code_of
endmodule : monitor_host_model

//--- verification/monitor_result_registers_bench.sv
`timescale 1ns/1ns
module monitor_result_registers_bench;
   logic        i_clk;
   logic        i_rstn;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic [15:0] reg_wdata;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        mode_wr;
   logic [2:0]  mode;
   logic        conv_done;
   logic [15:0] shunt;
   logic [12:0] bus;
   logic        range_32v;
   logic        ready;
   logic        busy;
   logic [15:0] d;
   int          fail_count;
   int          total_checks;
   int          cycles;

   monitor_host_model host (.i_clk(i_clk), .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));
   monitor_result_registers uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(reg_addr),
      .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .i_mode_wr(mode_wr), .i_mode(mode), .i_conv_done(conv_done), .i_shunt_code(shunt),
      .i_bus_code(bus), .i_range_32v(range_32v), .o_conversion_ready_flag(ready), .o_busy(busy));

   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   // The second cycle of the strobe carries inverted data while busy, so it must be dropped.
   task conv(input logic [15:0] s, input logic [12:0] b, input logic r);
      @(negedge i_clk);
      conv_done = 1'b1;
      shunt = s;
      bus = b;
      range_32v = r;
      @(negedge i_clk);
      shunt = ~s;
      bus = ~b;
      check({15'h0, busy}, 16'h0001);
      @(negedge i_clk);
      conv_done = 1'b0;
      repeat (4) @(negedge i_clk);
      check({15'h0, ready}, 16'h0001);
      check({15'h0, busy}, 16'h0000);
   endtask : conv

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fail_count++;
         close_out();
      end
   end

   initial
   begin
      i_rstn = 1'b0;
      mode_wr = 1'b0;
      mode = 3'h0;
      conv_done = 1'b0;
      shunt = 16'h0000;
      bus = 13'h0000;
      range_32v = 1'b0;
      fail_count = 0;
      total_checks = 0;
      cycles = 0;
      repeat (2) @(negedge i_clk);
      i_rstn = 1'b1;
      for (int a = 2; a < 8; a++)
      begin
         host.rd(8'(a), d);
         check(d, 16'h0000);
      end
      host.wr(8'h05, 16'h5001);
      host.wr(8'h03, 16'hFFFF);
      host.wr(8'h04, 16'h1234);
      host.rd(8'h05, d);
      check(d, 16'h5000);
      host.rd(8'h03, d);
      check(d, 16'h0000);
      host.rd(8'h04, d);
      check(d, 16'h0000);
      $display("test done: registers");
      conv(16'd2000, 13'h0BB3, 1'b0);
      host.rd(8'h02, d);
      check(d, {13'h0BB3, 3'b010});
      check(16'(host.bus_code_of(d)), 16'h0BB3);
      host.rd(8'h04, d);
      check(d, 16'(2000 * 20480 / 4096));
      host.rd(8'h03, d);
      check(d, 16'(10000 * 2995 / 4096));
      check({15'h0, ready}, 16'h0000);
      host.rd(8'h02, d);
      check(d, {13'h0BB3, 3'b000});
      conv(16'hF830, 13'h1FFF, 1'b1);
      host.rd(8'h02, d);
      check(d, {13'h1F40, 3'b010});
      host.rd(8'h04, d);
      check(d, 16'(-10000));
      host.rd(8'h03, d);
      check(d, 16'(10000 * 8000 / 4096));
      conv(16'h0000, 13'h1FFF, 1'b0);
      host.rd(8'h02, d);
      check(d, {13'h0FA0, 3'b010});
      $display("test done: conversions");
      host.wr(8'h05, 16'hFFFE);
      conv(16'h7FFF, 13'h0001, 1'b0);
      host.rd(8'h02, d);
      check(d, {13'h0001, 3'b011});
      host.rd(8'h04, d);
      check(d, 16'h7FFF);
      host.rd(8'h03, d);
      check(d, 16'h0007);
      $display("test done: overflow");
      for (int m = 0; m < 8; m++)
      begin
         conv(16'h0000, 13'h0000, 1'b0);
         mode_wr = 1'b1;
         mode = 3'(m);
         @(negedge i_clk);
         mode_wr = 1'b0;
         check({15'h0, ready}, 16'(m == 0 || m == 4));
      end
      $display("test done: modes");
      conv(16'd2000, 13'h0BB3, 1'b0);
      i_rstn = 1'b0;
      @(negedge i_clk);
      i_rstn = 1'b1;
      check({14'h0, busy, ready}, 16'h0000);
      for (int a = 2; a < 6; a++)
      begin
         host.rd(8'(a), d);
         check(d, 16'h0000);
      end
      $display("test done: reset");
      close_out();
   end
endmodule : monitor_result_registers_bench
